// file: rtl/e1f_framer.sv
// Summary of operation
// - Frames of 256 bits at 8 kHz
// - Alternate frames carry 0011011 in bits 2-8
// - Other frames send bit 2 as one
// - Bit 3 sends far-end alarm flag
// - Spare bits 4 to 8 send ones
// - Bit 1 always serves the check procedure
// - Sixteen-frame multiframe, two eight-frame halves
// - Each half is one 2048-bit check block
// - Even frames carry check bits first to last
// - Odd frames carry 001011 then error bits
// - Run check at 2048 kbit/s, report errors
// - Check word is previous half's remainder
// - Each faulty half clears one error bit, up to 15 pending
// - Receiver compares recomputed remainder with next
// - 32 slots of eight bits, slot 0 overhead
module e1f_framer (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0] htrans,
	input  wire logic       hwrite,
	input  wire logic [2:0] hsize,
	input  wire logic       hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]     hrdata,
	output logic            hreadyout,
	output logic            hresp,
	output logic            irq,
	input  wire logic       tx_payload,
	output logic            tx_data,
	output logic            tx_strobe,
	output logic            tx_mf_start,
	input  wire logic       rx_bit,
	input  wire logic       rx_bit_valid,
	input  wire logic       rx_mf_start,
	output logic            rx_payload,
	output logic            rx_payload_valid
);
	import e1f_pkg::*;

	// Bit 1 of even frames holds a check bit
	function automatic logic is_check_pos(input logic [7:0] bitn, input logic [3:0] frm);
		return (bitn == 8'h00) && !frm[0];
	endfunction

	logic [16:0]   nco_q;
	logic [7:0]    tx_bit_q;
	logic [3:0]    tx_frm_q, tx_chk_q, tx_rem, epend_q;
	logic          tick_q, tx_hm_end_q, tx_val, ep_inc, ep_dec;
	logic [1:0]    ctrl_q;
	logic [3:0]    int_sts_q, int_en_q, ev, clr;
	logic [15:0]   crc_errs_q;
	logic [7:0]    waddr_q;
	logic [31:0]   rd_mux;
	logic          wr_pend_q, aphase;
	e1f_rx_state_t rx_state_q;
	logic [7:0]    rx_bit_q, rx_pos_bit;
	logic [3:0]    rx_frm_q, rx_pos_frm, rx_rem, rx_calc_q, rx_rcv_q;
	logic          rx_track, rx_take, rx_hm_end_q, rx_alarm_q, crc_ev, febe_ev, alarm_ev, mf_ev;
	wire [17:0] nco_sum = {1'b0, nco_q} + {1'b0, NCO_STEP};

	// Fractional divider: one line bit every 100000/2048 clocks on average
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nco_q  <= 17'h0;
			tick_q <= 1'b0;
		end else if (nco_sum >= {1'b0, NCO_MOD}) begin
			nco_q  <= 17'(nco_sum - {1'b0, NCO_MOD});
			tick_q <= 1'b1;
		end else begin
			nco_q  <= nco_sum[16:0];
			tick_q <= 1'b0;
		end
	end

	// Bit and frame position of the bit now being sent
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_bit_q <= 8'h0;
			tx_frm_q <= 4'h0;
		end else if (tick_q) begin
			tx_bit_q <= tx_bit_q + 8'h1;
			if (tx_bit_q == LAST_BIT) begin
				tx_frm_q <= tx_frm_q + 4'h1;
			end
		end
	end

	// Content of the current transmit bit
	always_comb begin
		tx_val = tx_payload;
		if (tx_bit_q < FIRST_PAYLOAD) begin
			if (tx_bit_q == 8'h00) begin
				if (!tx_frm_q[0]) begin
					tx_val = tx_chk_q[2'd3 - tx_frm_q[2:1]] ^ ctrl_q[CTRL_INJECT];
				end else if (tx_frm_q < FIRST_EBIT_FRM) begin
					tx_val = MFAS[3'd5 - tx_frm_q[3:1]];
				end else begin
					tx_val = (epend_q == 4'h0);
				end
			end else if (!tx_frm_q[0]) begin
				tx_val = FAW[3'd7 - tx_bit_q[2:0]];
			end else if (tx_bit_q == BIT_FIXED) begin
				tx_val = 1'b1;
			end else if (tx_bit_q == BIT_ALARM) begin
				tx_val = ctrl_q[CTRL_ALARM];
			end else begin
				tx_val = SPARE_ONES[3'd7 - tx_bit_q[2:0]];
			end
		end
	end

	// Line outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_data     <= 1'b1;
			tx_strobe   <= 1'b0;
			tx_mf_start <= 1'b0;
		end else begin
			tx_strobe   <= tick_q;
			tx_mf_start <= tick_q && tx_bit_q == 8'h00 && tx_frm_q == 4'h0;
			if (tick_q) begin
				tx_data <= tx_val;
			end
		end
	end

	// Transmit check over each half, check positions counted as zero
	e1f_crc4 u_tx_crc (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clear   (tx_hm_end_q),
		.shift   (tick_q),
		.din     (tx_val & !is_check_pos(tx_bit_q, tx_frm_q)),
		.rem_q   (tx_rem)
	);

	// Remainder of one half is stored for the next half
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_hm_end_q <= 1'b0;
			tx_chk_q    <= 4'h0;
		end else begin
			tx_hm_end_q <= tick_q && tx_bit_q == LAST_BIT && tx_frm_q[2:0] == HALF_LAST;
			if (tx_hm_end_q) begin
				tx_chk_q <= tx_rem;
			end
		end
	end

	// Pending error indications, saturating at 15: one zero bit sent per faulty half received
	assign ep_inc = crc_ev && epend_q != EPEND_MAX;
	assign ep_dec = tick_q && tx_bit_q == 8'h00 && tx_frm_q[0] && tx_frm_q >= FIRST_EBIT_FRM &&
		epend_q != 4'h0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			epend_q <= 4'h0;
		end else if (ep_inc && !ep_dec) begin
			epend_q <= epend_q + 4'h1;
		end else if (ep_dec && !ep_inc) begin
			epend_q <= epend_q - 4'h1;
		end
	end

	// Receive position, restarted by the multiframe marker
	assign rx_track   = rx_state_q != RX_HUNT || (rx_bit_valid && rx_mf_start);
	assign rx_take    = rx_bit_valid && rx_track;
	assign rx_pos_bit = rx_mf_start ? 8'h00 : rx_bit_q;
	assign rx_pos_frm = rx_mf_start ? 4'h0 : rx_frm_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_bit_q <= 8'h0;
			rx_frm_q <= 4'h0;
		end else if (rx_take) begin
			rx_bit_q <= rx_pos_bit + 8'h1;
			if (rx_pos_bit == LAST_BIT) begin
				rx_frm_q <= rx_pos_frm + 4'h1;
			end else begin
				rx_frm_q <= rx_pos_frm;
			end
		end
	end

	// Receive check with check positions zeroed
	e1f_crc4 u_rx_crc (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clear   (rx_hm_end_q || (rx_bit_valid && rx_mf_start)),
		.shift   (rx_take),
		.din     (rx_bit & !is_check_pos(rx_pos_bit, rx_pos_frm)),
		.rem_q   (rx_rem)
	);

	// Receive sequencing: first half only computes, later halves also compare
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_state_q  <= RX_HUNT;
			rx_hm_end_q <= 1'b0;
			rx_calc_q   <= 4'h0;
		end else begin
			rx_hm_end_q <= rx_take && rx_pos_bit == LAST_BIT && rx_pos_frm[2:0] == HALF_LAST;
			case (rx_state_q)
				RX_HUNT: begin
					if (rx_bit_valid && rx_mf_start) begin
						rx_state_q <= RX_FIRST;
					end
				end
				RX_FIRST, RX_RUN: begin
					if (rx_bit_valid && rx_mf_start) begin
						rx_state_q <= RX_FIRST;
					end else if (rx_hm_end_q) begin
						rx_state_q <= RX_RUN;
					end
				end
				default: rx_state_q <= RX_HUNT;
			endcase
			if (rx_hm_end_q) begin
				rx_calc_q <= rx_rem;
			end
		end
	end

	// Received check bits, first bit stored as MSB
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_rcv_q <= 4'h0;
		end else if (rx_take && is_check_pos(rx_pos_bit, rx_pos_frm)) begin
			rx_rcv_q[2'd3 - rx_pos_frm[2:1]] <= rx_bit;
		end
	end

	// Far-end alarm flag from bit 3 of odd frames
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_alarm_q <= 1'b0;
		end else if (rx_take && rx_pos_frm[0] && rx_pos_bit == BIT_ALARM) begin
			rx_alarm_q <= rx_bit;
		end
	end

	// Payload bits of slots 1 to 31
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_payload       <= 1'b0;
			rx_payload_valid <= 1'b0;
		end else begin
			rx_payload_valid <= rx_take && rx_pos_bit >= FIRST_PAYLOAD;
			if (rx_take) begin
				rx_payload <= rx_bit;
			end
		end
	end

	// Events
	assign crc_ev   = rx_hm_end_q && rx_state_q == RX_RUN && rx_calc_q != rx_rcv_q;
	assign febe_ev  = rx_take && rx_pos_bit == 8'h00 && rx_pos_frm[0] &&
		rx_pos_frm >= FIRST_EBIT_FRM && !rx_bit;
	assign alarm_ev = rx_take && rx_pos_frm[0] && rx_pos_bit == BIT_ALARM && rx_bit && !rx_alarm_q;
	assign mf_ev    = tick_q && tx_bit_q == 8'h00 && tx_frm_q == 4'h0;
	assign ev       = {mf_ev, alarm_ev, febe_ev, crc_ev};

	// Saturating count of faulty received halves
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			crc_errs_q <= 16'h0;
		end else if (crc_ev && crc_errs_q != 16'hffff) begin
			crc_errs_q <= crc_errs_q + 16'h1;
		end
	end

	// AHB-Lite slave: zero wait states, read data registered in address phase
	assign aphase = hsel && hready && htrans[1];
	assign clr    = (wr_pend_q && waddr_q == A_INT_CLR) ? hwdata[NEV-1:0] : 4'h0;
	// Read data of the addressed register, zero when unmapped
	always_comb begin
		case (haddr[7:0])
			A_CTRL:     rd_mux = {30'h0, ctrl_q};
			A_STATUS:   rd_mux = {24'h0, epend_q, 2'h0, rx_alarm_q, rx_state_q == RX_RUN};
			A_INT_STS:  rd_mux = {28'h0, int_sts_q};
			A_INT_EN:   rd_mux = {28'h0, int_en_q};
			A_CRC_ERRS: rd_mux = {16'h0, crc_errs_q};
			default:    rd_mux = 32'h0;
		endcase
	end
	// Bus response, captured write address and registered read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			waddr_q   <= 8'h0;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend_q <= aphase && hwrite;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (aphase) begin
				waddr_q <= haddr[7:0];
			end
			if (aphase && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Writable registers, taken in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q   <= CTRL_RST;
			int_en_q <= INT_RST;
		end else if (wr_pend_q) begin
			if (waddr_q == A_CTRL) begin
				ctrl_q <= hwdata[1:0];
			end
			if (waddr_q == A_INT_EN) begin
				int_en_q <= hwdata[NEV-1:0];
			end
		end
	end

	// Sticky status, a new event wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_sts_q <= INT_RST;
			irq       <= 1'b0;
		end else begin
			int_sts_q <= (int_sts_q & ~clr) | ev;
			irq       <= |(int_sts_q & int_en_q);
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	frame_wrap_a: assert property (tick_q && tx_bit_q == LAST_BIT && tx_frm_q == LAST_FRAME
		|=> tx_bit_q == 8'h00 && tx_frm_q == 4'h0) else $error("frame counters did not wrap");
	bit_spacing_a: assert property (tick_q |=> !tick_q [*8])
		else $error("line bits too close");
	faw_bits_a: assert property (tick_q && !tx_frm_q[0] && tx_bit_q != 8'h00 &&
		tx_bit_q < FIRST_PAYLOAD |=> tx_data == FAW[3'd7 - $past(tx_bit_q[2:0])])
		else $error("alignment word bit wrong");
	fixed_one_a: assert property (tick_q && tx_frm_q[0] && tx_bit_q == BIT_FIXED
		|=> tx_data) else $error("fixed bit not one");
	alarm_bit_a: assert property (tick_q && tx_frm_q[0] && tx_bit_q == BIT_ALARM
		|=> tx_data == $past(ctrl_q[CTRL_ALARM])) else $error("alarm bit wrong");
	spare_ones_a: assert property (tick_q && tx_frm_q[0] && tx_bit_q > BIT_ALARM &&
		tx_bit_q < FIRST_PAYLOAD |=> tx_data) else $error("spare bit not one");
	mfas_bits_a: assert property (tick_q && tx_bit_q == 8'h00 && tx_frm_q[0] &&
		tx_frm_q < FIRST_EBIT_FRM |=> tx_data == MFAS[3'd5 - $past(tx_frm_q[3:1])])
		else $error("multiframe pattern bit wrong");
	check_bits_a: assert property (tick_q && tx_bit_q == 8'h00 && !tx_frm_q[0] &&
		!ctrl_q[CTRL_INJECT] |=> tx_data == $past(tx_chk_q[2'd3 - tx_frm_q[2:1]]))
		else $error("check bit wrong");
	half_latch_a: assert property (tick_q && tx_bit_q == LAST_BIT && tx_frm_q[2:0] == HALF_LAST
		|=> ##1 tx_chk_q == $past(tx_rem)) else $error("remainder not stored");
	ebit_count_a: assert property (crc_ev && epend_q != EPEND_MAX && !ep_dec
		|=> epend_q == $past(epend_q) + 4'h1) else $error("error indication not queued");
	rx_compare_a: assert property (rx_hm_end_q && rx_state_q == RX_RUN &&
		rx_calc_q != rx_rcv_q |=> int_sts_q[EV_CRC]) else $error("check mismatch not flagged");
	irq_level_a: assert property ((int_sts_q & int_en_q) != 4'h0 |=> irq)
		else $error("interrupt not raised");
	mf_start_c: cover property (tx_mf_start);
	crc_err_c: cover property (crc_ev);
	febe_c: cover property (febe_ev ##[1:1000] rx_hm_end_q);
	alarm_c: cover property (alarm_ev);
endmodule

// file: inc/e1f_pkg.sv
package e1f_pkg;

	// Clock and line timing
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          CLK_KHZ        = 1000000 / CLK_PERIOD_NS;
	localparam int          LINE_KBPS      = 2048;
	localparam int          FRAME_RATE_KHZ = 8;
	localparam logic [16:0] NCO_STEP       = 17'(LINE_KBPS);
	localparam logic [16:0] NCO_MOD        = 17'(CLK_KHZ);

	// Frame geometry
	localparam int          FRAME_BITS     = LINE_KBPS / FRAME_RATE_KHZ;
	localparam int          SLOT_BITS      = 8;
	localparam int          SLOTS          = FRAME_BITS / SLOT_BITS;
	localparam logic [7:0]  LAST_BIT       = 8'(FRAME_BITS - 1);
	localparam logic [7:0]  FIRST_PAYLOAD  = 8'(SLOT_BITS);
	localparam logic [3:0]  LAST_FRAME     = 4'hf;
	localparam logic [2:0]  HALF_LAST      = 3'h7;
	localparam logic [3:0]  FIRST_EBIT_FRM = 4'hd;

	// Slot 0 contents
	localparam logic [6:0]  FAW            = 7'h1b;
	localparam logic [5:0]  MFAS           = 6'h0b;
	localparam logic [4:0]  SPARE_ONES     = 5'h1f;
	localparam logic [7:0]  BIT_FIXED      = 8'h01;
	localparam logic [7:0]  BIT_ALARM      = 8'h02;

	// Check polynomial, low terms of x^4+x+1
	localparam logic [3:0]  CRC_POLY_LOW   = 4'h3;
	localparam logic [3:0]  EPEND_MAX      = 4'hf;

	// Register byte addresses
	localparam logic [7:0]  A_CTRL         = 8'h00;
	localparam logic [7:0]  A_STATUS       = 8'h04;
	localparam logic [7:0]  A_INT_STS      = 8'h08;
	localparam logic [7:0]  A_INT_EN       = 8'h0c;
	localparam logic [7:0]  A_INT_CLR      = 8'h10;
	localparam logic [7:0]  A_CRC_ERRS     = 8'h14;

	// Field positions and reset values
	localparam int          CTRL_ALARM     = 0;
	localparam int          CTRL_INJECT    = 1;
	localparam logic [1:0]  CTRL_RST       = 2'h0;
	localparam int          ST_LOCK        = 0;
	localparam int          ST_FAR_ALARM   = 1;
	localparam int          ST_EPEND       = 4;
	localparam int          EV_CRC         = 0;
	localparam int          EV_FEBE        = 1;
	localparam int          EV_ALARM       = 2;
	localparam int          EV_MF          = 3;
	localparam int          NEV            = 4;
	localparam logic [3:0]  INT_RST        = 4'h0;

	typedef enum logic [1:0] {RX_HUNT, RX_FIRST, RX_RUN} e1f_rx_state_t;

endpackage

// file: rtl/e1f_crc4.sv
module e1f_crc4 (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       clear,
	input  wire logic       shift,
	input  wire logic       din,
	output logic [3:0]      rem_q
);
	import e1f_pkg::*;

	// One serial step of multiply by x^4 and divide by x^4+x+1, MSB first
	function automatic logic [3:0] crc_step(input logic [3:0] r, input logic d);
		logic fb;
		fb = d ^ r[3];
		return {r[2:0], 1'b0} ^ (fb ? CRC_POLY_LOW : 4'h0);
	endfunction

	// Clear may coincide with the first bit of the next block
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rem_q <= 4'h0;
		end else if (clear) begin
			rem_q <= shift ? crc_step(4'h0, din) : 4'h0;
		end else if (shift) begin
			rem_q <= crc_step(rem_q, din);
		end
	end

endmodule

// file: bench/e1f_tb_pkg.sv
package e1f_tb_pkg;
	import e1f_pkg::*;

	// Serial remainder step for x^4+x+1, first bit most significant
	function automatic logic [3:0] crc_step(input logic [3:0] r, input logic b);
		return {r[2:0], 1'b0} ^ ((r[3] ^ b) ? CRC_POLY_LOW : 4'h0);
	endfunction

	// Expected bit n (1..8) of slot 0 in frame f; c check word, a alarm, e error bit
	function automatic logic ovh_bit(input int f, input int n, input logic [3:0] c,
		input logic a, input logic e);
		if (n == 1 && f % 2 == 0)
			return c[3 - (f % 8) / 2];
		if (n == 1)
			return (f >= 13) ? e : MFAS[5 - f / 2];
		if (f % 2 == 0)
			return FAW[8 - n];
		if (n == 2)
			return 1'b1;
		if (n == 3)
			return a;
		return 1'b1;
	endfunction

endpackage

// file: bench/e1f_peer.sv
module e1f_peer (
	input  wire logic hclk,
	output logic      rx_bit,
	output logic      rx_bit_valid,
	output logic      rx_mf_start
);
	timeunit 1ns;
	timeprecision 1ps;
	import e1f_tb_pkg::*;

	logic [3:0] crc_q     = 4'h0;
	logic [3:0] sent_q    = 4'h0;
	logic       started_q = 1'b0;
	logic       b;

	// Lines quiet before the first frame
	initial begin
		rx_bit       = 1'b0;
		rx_bit_valid = 1'b0;
		rx_mf_start  = 1'b0;
	end

	// Sends one multiframe; bad flips the first check bit of the second half
	task automatic send_mf(input logic a, input logic bad, input logic ez);
		for (int f = 0; f < 16; f++) begin
			for (int n = 1; n <= 256; n++) begin
				if (n == 1 && f % 8 == 0) begin
					sent_q = crc_q;
					crc_q  = 4'h0;
				end
				b = (n <= 8) ? ovh_bit(f, n, sent_q ^ {bad && f >= 8, 3'h0}, a, !ez)
					: 1'($urandom);
				crc_q = crc_step(crc_q, (n == 1 && f % 2 == 0) ? 1'b0 : b);
				rx_bit       <= b;
				rx_bit_valid <= 1'b1;
				rx_mf_start  <= !started_q && f == 0 && n == 1;
				@(posedge hclk);
				started_q = 1'b1;
				rx_bit_valid <= 1'b0;
				rx_mf_start  <= 1'b0;
				rx_bit       <= !b; // Released line shows no stale value
				repeat (1 + $urandom_range(1)) @(posedge hclk);
			end
		end
	endtask

endmodule

// file: bench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import e1f_pkg::*;
	import e1f_tb_pkg::*;

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic        tx_payload  = 1'b0;
	logic        tx_data;
	logic        tx_strobe;
	logic        tx_mf_start;
	logic        rx_bit;
	logic        rx_bit_valid;
	logic        rx_mf_start;
	logic        rx_payload;
	logic        rx_payload_valid;
	int          err_total   = 0;
	int          checks_done = 0;
	int          frm         = -1;
	int          pos         = 0;
	int          gap         = 0;
	int          fstart      = 0;
	int          ncyc        = 0;
	int          nvalid      = 0;
	logic        exp_alarm   = 1'b0;
	logic        exp_inj     = 1'b0;
	logic [3:0]  tcrc        = 4'h0;
	logic [3:0]  tsent       = 4'h0;
	logic        ebit;
	logic        last_rx     = 1'b0;
	logic [31:0] rd;

	e1f_framer dut (
		.hclk             (hclk),
		.hresetn          (hresetn),
		.hsel             (hsel),
		.haddr            (haddr),
		.htrans           (htrans),
		.hwrite           (hwrite),
		.hsize            (hsize),
		.hready           (hreadyout),
		.hwdata           (hwdata),
		.hrdata           (hrdata),
		.hreadyout        (hreadyout),
		.hresp            (hresp),
		.irq              (irq),
		.tx_payload       (tx_payload),
		.tx_data          (tx_data),
		.tx_strobe        (tx_strobe),
		.tx_mf_start      (tx_mf_start),
		.rx_bit           (rx_bit),
		.rx_bit_valid     (rx_bit_valid),
		.rx_mf_start      (rx_mf_start),
		.rx_payload       (rx_payload),
		.rx_payload_valid (rx_payload_valid)
	);

	e1f_peer peer (
		.hclk         (hclk),
		.rx_bit       (rx_bit),
		.rx_bit_valid (rx_bit_valid),
		.rx_mf_start  (rx_mf_start)
	);

	// 100 MHz clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Bounded wait for hready high at a rising edge
	task automatic wait_rdy();
		for (int n = 0; n < 64; n++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				return;
		end
		err_total++;
		end_sim();
	endtask

	// One single word transfer; read data taken at the end of the data phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize  <= 3'h2;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		chk("hresp", 32'h0, 32'(hresp));
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(nm, e, rd & m);
	endtask

	// Follows the transmit stream: spacing, frame period, multiframe mark, slot 0, check word
	always @(posedge hclk) begin
		ncyc++;
		gap++;
		if (tx_strobe === 1'b1) begin
			tx_payload <= 1'($urandom);
			if (frm >= 0)
				chk("strobe gap", 32'h1, 32'(gap == 48 || gap == 49));
			gap = 0;
			pos++;
			if (frm < 0 || pos == 256) begin
				if (frm >= 0)
					chk("frame period", 32'd12500, 32'(ncyc - fstart));
				fstart = ncyc;
				frm++;
				pos = 0;
			end
			chk("mf start", 32'(frm % 16 == 0 && pos == 0), 32'(tx_mf_start));
			if (pos == 0 && frm % 8 == 0) begin
				tsent = tcrc;
				tcrc  = 4'h0;
			end
			ebit = ovh_bit(frm % 16, pos + 1, tsent, exp_alarm, 1'b1);
			if (exp_inj && pos == 0 && frm % 2 == 0)
				ebit = !ebit;
			if (pos < 8)
				chk("slot0 bit", 32'(ebit), 32'(tx_data));
			else
				chk("tx payload", 32'(tx_payload), 32'(tx_data));
			tcrc = crc_step(tcrc, (pos == 0 && frm % 2 == 0) ? 1'b0 : tx_data);
		end
	end

	// Received payload mirrors the bit taken one cycle earlier
	always @(posedge hclk) begin
		if (rx_payload_valid === 1'b1) begin
			nvalid++;
			chk("rx payload", 32'(last_rx), 32'(rx_payload));
		end
		if (rx_bit_valid === 1'b1)
			last_rx = rx_bit;
	end

	// Main sequence
	initial begin
		hresetn    = 1'b0;
		hsel       = 1'b0;
		haddr      = 32'h0;
		htrans     = 2'h0;
		hwrite     = 1'b0;
		hsize      = 3'h2;
		hwdata     = 32'h0;
		void'($urandom(71166));
		repeat (4) @(posedge hclk);
		chk("reset outs", 32'h24,
			{26'h0, hreadyout, hresp, irq, tx_data, tx_strobe, rx_payload_valid});
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("int sts rst", A_INT_STS, 32'hf, 32'h0);
		rchk("ctrl rst", A_CTRL, 32'h3, 32'(CTRL_RST));
		rchk("int en rst", A_INT_EN, 32'hf, 32'(INT_RST));
		rchk("status rst", A_STATUS, 32'hf3, 32'h0);
		ahb(1'b1, 8'h40, 32'hffffffff);
		rchk("unmapped", 8'h40, 32'hffffffff, 32'h0);
		ahb(1'b1, A_CTRL, 32'h1);
		rchk("ctrl rw", A_CTRL, 32'h3, 32'h1);
		ahb(1'b1, A_CTRL, 32'h0);
		// Clean multiframe, then one with a bad check bit, alarm and zero error bits
		peer.send_mf(1'b0, 1'b0, 1'b0);
		repeat (3) @(posedge hclk);
		rchk("status run", A_STATUS, 32'hf3, 32'h1);
		rchk("crc errs", A_CRC_ERRS, 32'hffff, 32'h0);
		peer.send_mf(1'b1, 1'b1, 1'b1);
		repeat (3) @(posedge hclk);
		rchk("crc errs", A_CRC_ERRS, 32'hffff, 32'h1);
		rchk("status err", A_STATUS, 32'hf3, 32'h13);
		rchk("int sts", A_INT_STS, 32'h7, 32'h7);
		chk("irq masked", 32'h0, 32'(irq));
		ahb(1'b1, A_INT_EN, 32'h4);
		rchk("int en", A_INT_EN, 32'hf, 32'h4);
		chk("irq on", 32'h1, 32'(irq));
		ahb(1'b1, A_INT_CLR, 32'h4);
		rchk("int clr", A_INT_STS, 32'hf, 32'hb);
		chk("irq off", 32'h0, 32'(irq));
		ahb(1'b1, A_INT_CLR, 32'hf);
		rchk("int clr all", A_INT_STS, 32'hf, 32'h0);
		peer.send_mf(1'b0, 1'b0, 1'b0);
		repeat (3) @(posedge hclk);
		rchk("crc errs", A_CRC_ERRS, 32'hffff, 32'h1);
		rchk("status ok", A_STATUS, 32'hf3, 32'h11);
		rchk("int sts ok", A_INT_STS, 32'h7, 32'h0);
		chk("payload count", 32'd11904, 32'(nvalid));
		// Far-end alarm and check bit inversion from frame 4, inversion off in frame 7
		for (int n = 0; n < 60000 && frm < 4; n++)
			@(posedge hclk);
		chk("frame 4 reached", 32'h1, 32'(frm >= 4));
		ahb(1'b1, A_CTRL, 32'h3);
		exp_alarm = 1'b1;
		exp_inj   = 1'b1;
		for (int n = 0; n < 40000 && frm < 7; n++)
			@(posedge hclk);
		chk("frame 7 reached", 32'h1, 32'(frm >= 7));
		ahb(1'b1, A_CTRL, 32'h1);
		exp_inj   = 1'b0;
		for (int n = 0; n < 40000 && !(frm >= 8 && pos >= 8); n++)
			@(posedge hclk);
		chk("tx reached", 32'h1, 32'(frm >= 8 && pos >= 8));
		end_sim();
	end

endmodule
